// [hdl/tsc_pkg.sv]
package tsc_pkg;
   // register byte offsets on the apb side
   localparam logic [11:0] TSC_CTRL_OFS   = 12'h000;
   localparam logic [11:0] TSC_PRIO_OFS   = 12'h004;
   // field positions of trap_control_status
   localparam int unsigned TSC_NEST_DIS   = 15;
   localparam int unsigned TSC_OVA_FLAG   = 14;
   localparam int unsigned TSC_OVB_FLAG   = 13;
   localparam int unsigned TSC_COVA_FLAG  = 12;
   localparam int unsigned TSC_COVB_FLAG  = 11;
   localparam int unsigned TSC_OVA_EN     = 10;
   localparam int unsigned TSC_OVB_EN     = 9;
   localparam int unsigned TSC_COV_EN     = 8;
   localparam int unsigned TSC_SHIFT_FLAG = 7;
   localparam int unsigned TSC_DIV0_FLAG  = 6;
   localparam int unsigned TSC_DMA_FLAG   = 5;
   localparam int unsigned TSC_MATH_FLAG  = 4;
   localparam int unsigned TSC_ADDR_FLAG  = 3;
   localparam int unsigned TSC_STACK_FLAG = 2;
   localparam int unsigned TSC_OSC_FLAG   = 1;
   // masks and values after reset
   localparam logic [15:0] TSC_IMPL_MASK  = 16'hfffe;
   localparam logic [15:0] TSC_FLAG_MASK  = 16'h78fe;
   localparam logic [15:0] TSC_CTRL_RST   = 16'h0000;
   localparam logic [2:0]  TSC_PRIO_RST   = 3'h0;
   localparam int unsigned TSC_PRIO_W     = 3;
   localparam int unsigned TSC_REG_W      = 16;
endpackage

// [hdl/tsc_trap_if.sv]
`timescale 1ns/1ps
// trap enables out of the register file, flag set strobes back into it
interface tsc_trap_if;
   logic        ova_en;
   logic        ovb_en;
   logic        cov_en;
   logic [15:0] set_vec;
   logic        math_trap;
   logic        any_trap;
   modport detector (input ova_en, ovb_en, cov_en, output set_vec, math_trap, any_trap);
   modport regfile  (output ova_en, ovb_en, cov_en, input set_vec, math_trap, any_trap);
endinterface

// [hdl/tsc_trap_detect.sv]
`timescale 1ns/1ps
// turns raw core error events into trap strobes and flag set bits
module tsc_trap_detect
   import tsc_pkg::*;
(
   input  wire logic    i_ovf_a,      // ordinary overflow of accumulator a
   input  wire logic    i_ovf_b,      // ordinary overflow of accumulator b
   input  wire logic    i_cat_a,      // catastrophic overflow of accumulator a
   input  wire logic    i_cat_b,      // catastrophic overflow of accumulator b
   input  wire logic    i_bad_shift,  // invalid accumulator shift
   input  wire logic    i_zero_div,   // divide with zero divisor
   input  wire logic    i_dma_fault,  // dma controller error
   input  wire logic    i_addr_fault, // address error
   input  wire logic    i_stack_fault,// stack error
   input  wire logic    i_osc_fault,  // oscillator failure
   tsc_trap_if.detector trap          // enables in, set strobes out
);
   logic ova_trap;
   logic ovb_trap;
   logic cova_trap;
   logic covb_trap;

   // overflow events only become traps when their enable is set
   assign ova_trap  = i_ovf_a & trap.ova_en;   // [RULE_06]
   assign ovb_trap  = i_ovf_b & trap.ovb_en;   // [RULE_07]
   assign cova_trap = i_cat_a & trap.cov_en;   // [RULE_08]
   assign covb_trap = i_cat_b & trap.cov_en;   // [RULE_08]

   // accumulator traps and shift or divide errors all count as math traps
   assign trap.math_trap = ova_trap | ovb_trap | cova_trap | covb_trap
                           | i_bad_shift | i_zero_div;
   assign trap.any_trap  = trap.math_trap | i_dma_fault | i_addr_fault
                           | i_stack_fault | i_osc_fault;

   // one set bit per flag; bit 0 and the control bits never set here
   always_comb
   begin
      trap.set_vec                 = '0;
      trap.set_vec[TSC_OVA_FLAG]   = ova_trap;        // [RULE_02]
      trap.set_vec[TSC_OVB_FLAG]   = ovb_trap;        // [RULE_03]
      trap.set_vec[TSC_COVA_FLAG]  = cova_trap;       // [RULE_04]
      trap.set_vec[TSC_COVB_FLAG]  = covb_trap;       // [RULE_05]
      trap.set_vec[TSC_SHIFT_FLAG] = i_bad_shift;     // [RULE_09]
      trap.set_vec[TSC_DIV0_FLAG]  = i_zero_div;      // [RULE_10]
      trap.set_vec[TSC_DMA_FLAG]   = i_dma_fault;     // [RULE_11]
      trap.set_vec[TSC_MATH_FLAG]  = trap.math_trap;  // [RULE_12]
      trap.set_vec[TSC_ADDR_FLAG]  = i_addr_fault;    // [RULE_15]
      trap.set_vec[TSC_STACK_FLAG] = i_stack_fault;   // [RULE_15]
      trap.set_vec[TSC_OSC_FLAG]   = i_osc_fault;     // [RULE_15]
   end
endmodule

// [hdl/tsc_trap_status_control.sv]
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
// What this block does
// RULE_01: nesting disable bit 15 set forbids interrupt nesting; clear allows it.
// RULE_02: bit 14 flags a trap caused by accumulator a overflow.
// RULE_03: bit 13 flags a trap caused by accumulator b overflow.
// RULE_04: bit 12 flags a trap caused by catastrophic overflow of accumulator a.
// RULE_05: bit 11 flags a trap caused by catastrophic overflow of accumulator b.
// RULE_06: bit 10 enables trapping on ordinary overflow of accumulator a.
// RULE_07: bit 9 enables trapping on ordinary overflow of accumulator b.
// RULE_08: bit 8 enables trapping on catastrophic overflow of either accumulator.
// RULE_09: bit 7 flags a math trap caused by an invalid accumulator shift.
// RULE_10: bit 6 flags a math trap caused by divide by zero.
// RULE_11: bit 5 flags a dma controller error trap.
// RULE_12: bit 4 flags any math error trap.
// RULE_13: bit 0 is unimplemented; writes ignored, reads zero.
// RULE_14: cpu priority level is read-only to software while nesting is disabled.
// RULE_15: bits 3, 2, 1 flag address, stack and oscillator failure traps.
// RULE_16: all bits reset to zero; flags stay until software writes zero; all read/write. Bit 0 is not: it reads zero and ignores writes.
module tsc_trap_status_control
   import tsc_pkg::*;
(
   input  wire logic        i_ref_clk,        // system clock, 125 mhz
   input  wire logic        i_arst_n,         // async reset, active low
   input  wire logic        psel,             // apb select
   input  wire logic        penable,          // apb access phase
   input  wire logic        pwrite,           // apb write
   input  wire logic [11:0] paddr,            // apb byte address
   input  wire logic [31:0] pwdata,           // apb write data
   input  wire logic [3:0]  pstrb,            // apb byte strobes
   output logic      [31:0] prdata,           // apb read data, from flops
   output logic             pready,           // apb ready
   output logic             pslverr,          // apb error on unmapped address
   input  wire logic        i_ovf_a,          // accumulator a overflow pulse
   input  wire logic        i_ovf_b,          // accumulator b overflow pulse
   input  wire logic        i_cat_a,          // accumulator a catastrophic pulse
   input  wire logic        i_cat_b,          // accumulator b catastrophic pulse
   input  wire logic        i_bad_shift,      // invalid shift pulse
   input  wire logic        i_zero_div,       // divide by zero pulse
   input  wire logic        i_dma_fault,      // dma error pulse
   input  wire logic        i_addr_fault,     // address error pulse
   input  wire logic        i_stack_fault,    // stack error pulse
   input  wire logic        i_osc_fault,      // oscillator failure pulse
   input  wire logic        i_prio_load,      // core loads a new priority level
   input  wire logic [2:0]  i_prio_value,     // level loaded by the core
   output logic             o_nesting_disable,// interrupt nesting forbidden
   output logic             o_math_trap,      // math trap raised this cycle
   output logic             o_any_trap,       // some trap raised this cycle
   output logic [2:0]       o_cpu_priority_level // current cpu priority level
);
   logic                    rst_meta_q;
   logic                    rst_n_q;
   logic [TSC_REG_W-1:0]    ctrl_q;
   logic [TSC_REG_W-1:0]    ctrl_d;
   logic [TSC_PRIO_W-1:0]   prio_q;
   logic [TSC_PRIO_W-1:0]   prio_d;
   logic [31:0]             rdata_q;
   logic                    err_q;
   logic                    setup;
   logic                    access;
   logic                    ctrl_hit;
   logic                    prio_hit;
   logic                    wr_ctrl;
   logic                    wr_prio;
   logic [TSC_REG_W-1:0]    wmask;
   logic [TSC_REG_W-1:0]    rd_ctrl;

   tsc_trap_if trap ();

   // reset enters async, released through two flops
   always_ff @(posedge i_ref_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   tsc_trap_detect u_detect (
      .i_ovf_a       (i_ovf_a),
      .i_ovf_b       (i_ovf_b),
      .i_cat_a       (i_cat_a),
      .i_cat_b       (i_cat_b),
      .i_bad_shift   (i_bad_shift),
      .i_zero_div    (i_zero_div),
      .i_dma_fault   (i_dma_fault),
      .i_addr_fault  (i_addr_fault),
      .i_stack_fault (i_stack_fault),
      .i_osc_fault   (i_osc_fault),
      .trap          (trap.detector)
   );

   // enables feed the detector straight from the register
   assign trap.ova_en = ctrl_q[TSC_OVA_EN];   // [RULE_06]
   assign trap.ovb_en = ctrl_q[TSC_OVB_EN];   // [RULE_07]
   assign trap.cov_en = ctrl_q[TSC_COV_EN];   // [RULE_08]

   // apb phases and address decode
   assign setup    = psel & ~penable;
   assign access   = psel & penable;
   always_comb
   begin
      ctrl_hit = 1'b0;
      prio_hit = 1'b0;
      if (paddr == TSC_CTRL_OFS)
      begin
         ctrl_hit = 1'b1;
      end
      else if (paddr == TSC_PRIO_OFS)
      begin
         prio_hit = 1'b1;
      end
   end

   // zero wait states: read data is caught in setup, so pready can be fixed
   assign pready  = 1'b1;
   assign pslverr = access & err_q;
   assign prdata  = rdata_q;

   // writes land only at the access edge, lanes gated by pstrb
   assign wr_ctrl = access & pwrite & ctrl_hit;
   assign wr_prio = access & pwrite & prio_hit & pstrb[0];
   assign wmask   = {{8{pstrb[1]}}, {8{pstrb[0]}}} & {16{wr_ctrl}};

   // per bit: hardware set wins over a software clear in the same cycle
   for (genvar b = 0; b < TSC_REG_W; b++)
   begin : g_bit
      always_comb
      begin
         if (!TSC_IMPL_MASK[b])
         begin
            ctrl_d[b] = 1'b0;                                   // [RULE_13]
         end
         else
         begin
            ctrl_d[b] = (wmask[b] ? pwdata[b] : ctrl_q[b])      // [RULE_16]
                        | (TSC_FLAG_MASK[b] & trap.set_vec[b]);
         end
      end
   end

   // control and status register
   always_ff @(posedge i_ref_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         ctrl_q <= TSC_CTRL_RST;                                // [RULE_16]
      end
      else
      begin
         ctrl_q <= ctrl_d;
      end
   end

   // priority level: core load first, software only while nesting is allowed
   always_comb
   begin
      prio_d = prio_q;
      if (i_prio_load)
      begin
         prio_d = i_prio_value;
      end
      else if (wr_prio && !ctrl_q[TSC_NEST_DIS])
      begin
         prio_d = pwdata[TSC_PRIO_W-1:0];                        // [RULE_14]
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         prio_q <= TSC_PRIO_RST;
      end
      else
      begin
         prio_q <= prio_d;
      end
   end

   // read view of the control register, bit 0 forced low
   assign rd_ctrl = ctrl_q & TSC_IMPL_MASK;                     // [RULE_13]

   // read data and error caught in setup; held through the access phase
   always_ff @(posedge i_ref_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         rdata_q <= 32'h0000_0000;
         err_q   <= 1'b0;
      end
      else if (setup)
      begin
         err_q <= ~(ctrl_hit | prio_hit);
         if (pwrite)
         begin
            rdata_q <= 32'h0000_0000;
         end
         else if (ctrl_hit)
         begin
            rdata_q <= {16'h0000, rd_ctrl};
         end
         else if (prio_hit)
         begin
            rdata_q <= {29'h0000_0000, prio_q};
         end
         else
         begin
            rdata_q <= 32'h0000_0000;
         end
      end
   end

   // nesting control and trap strobes to the interrupt core
   assign o_nesting_disable    = ctrl_q[TSC_NEST_DIS];          // [RULE_01]
   assign o_cpu_priority_level = prio_q;
   assign o_math_trap          = trap.math_trap;
   assign o_any_trap           = trap.any_trap;

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!rst_n_q);

   // a flag that is set stays set unless software writes zero to it
   a_flag_sticky: assert property ( // [RULE_16]
      $past(ctrl_q[TSC_DMA_FLAG]) && !$past(wmask[TSC_DMA_FLAG]) |-> ctrl_q[TSC_DMA_FLAG])
      else $error("dma flag dropped without a clear");

   a_bit0_zero: assert property ( // [RULE_13]
      wr_ctrl && pwdata[0] |=> prdata[0] == 1'b0 && ctrl_q[0] == 1'b0)
      else $error("bit 0 took a value");

   a_ova_gated: assert property ( // [RULE_06]
      i_ovf_a && !ctrl_q[TSC_OVA_EN] && !ctrl_q[TSC_OVA_FLAG] && !wmask[TSC_OVA_FLAG]
      |=> !ctrl_q[TSC_OVA_FLAG])
      else $error("overflow a flagged while disabled");

   a_ova_flag: assert property ( // [RULE_02]
      i_ovf_a && ctrl_q[TSC_OVA_EN] |=> ctrl_q[TSC_OVA_FLAG] && ctrl_q[TSC_MATH_FLAG])
      else $error("overflow a trap not flagged");

   a_ovb_flag: assert property ( // [RULE_03]
      i_ovf_b && ctrl_q[TSC_OVB_EN] |=> ctrl_q[TSC_OVB_FLAG])
      else $error("overflow b trap not flagged");

   a_cat_flags: assert property ( // [RULE_08]
      (i_cat_a || i_cat_b) && ctrl_q[TSC_COV_EN] |-> o_math_trap
      ##1 (ctrl_q[TSC_COVA_FLAG] || ctrl_q[TSC_COVB_FLAG]))
      else $error("catastrophic trap not flagged");

   a_div_math: assert property ( // [RULE_10]
      i_zero_div |=> ctrl_q[TSC_DIV0_FLAG] && ctrl_q[TSC_MATH_FLAG])
      else $error("divide by zero not flagged");

   a_shift_math: assert property ( // [RULE_09]
      i_bad_shift |-> o_math_trap ##1 ctrl_q[TSC_SHIFT_FLAG])
      else $error("bad shift not flagged");

   a_set_wins: assert property ( // [RULE_15]
      i_stack_fault && wr_ctrl && pstrb[0] && !pwdata[TSC_STACK_FLAG]
      |=> ctrl_q[TSC_STACK_FLAG])
      else $error("stack flag lost to a clear");

   a_prio_locked: assert property ( // [RULE_14]
      ctrl_q[TSC_NEST_DIS] && !i_prio_load |=> $stable(prio_q))
      else $error("priority level changed while nesting disabled");

   a_nest_out: assert property ( // [RULE_01]
      wr_ctrl && pstrb[1] |=> o_nesting_disable == $past(pwdata[TSC_NEST_DIS]))
      else $error("nesting disable not written");

   a_read_ctrl: assert property ( // [RULE_16]
      setup && !pwrite && ctrl_hit |=> prdata[15:0] == $past(rd_ctrl))
      else $error("control read mismatch");

   // gating: with its enable clear an overflow must leave its flag alone
   a_ovb_gated: assert property ( // [RULE_07]
      i_ovf_b && !ctrl_q[TSC_OVB_EN] && !ctrl_q[TSC_OVB_FLAG] && !wmask[TSC_OVB_FLAG]
      |=> !ctrl_q[TSC_OVB_FLAG])
      else $error("overflow b flagged while disabled");

   // both catastrophic flags share the upper lane, so one wmask bit covers them
   a_cat_gated: assert property ( // [RULE_08]
      (i_cat_a || i_cat_b) && !ctrl_q[TSC_COV_EN] && !wmask[TSC_COVA_FLAG]
      && !ctrl_q[TSC_COVA_FLAG] && !ctrl_q[TSC_COVB_FLAG]
      |=> !ctrl_q[TSC_COVA_FLAG] && !ctrl_q[TSC_COVB_FLAG])
      else $error("catastrophic overflow flagged while disabled");

   // each enabled cause lands in its own flag on the next edge
   a_cova_flag: assert property ( // [RULE_04]
      i_cat_a && ctrl_q[TSC_COV_EN] |=> ctrl_q[TSC_COVA_FLAG] && ctrl_q[TSC_MATH_FLAG])
      else $error("catastrophic a trap not flagged");

   a_covb_flag: assert property ( // [RULE_05]
      i_cat_b && ctrl_q[TSC_COV_EN] |=> ctrl_q[TSC_COVB_FLAG] && ctrl_q[TSC_MATH_FLAG])
      else $error("catastrophic b trap not flagged");

   a_dma_flag: assert property ( // [RULE_11]
      i_dma_fault |=> ctrl_q[TSC_DMA_FLAG])
      else $error("dma fault not flagged");

   a_addr_flag: assert property ( // [RULE_15]
      i_addr_fault |=> ctrl_q[TSC_ADDR_FLAG])
      else $error("address fault not flagged");

   a_stack_flag: assert property ( // [RULE_15]
      i_stack_fault |=> ctrl_q[TSC_STACK_FLAG])
      else $error("stack fault not flagged");

   a_osc_flag: assert property ( // [RULE_15]
      i_osc_fault |=> ctrl_q[TSC_OSC_FLAG])
      else $error("oscillator fault not flagged");

   a_any_fault: assert property ( // [RULE_15]
      i_dma_fault || i_addr_fault || i_stack_fault || i_osc_fault |-> o_any_trap)
      else $error("fault raised no trap strobe");

   // the summary flag may only rise from a math trap or a software write of one
   a_math_cause: assert property ( // [RULE_12]
      !o_math_trap && !ctrl_q[TSC_MATH_FLAG] && !(wmask[TSC_MATH_FLAG] && pwdata[TSC_MATH_FLAG])
      |=> !ctrl_q[TSC_MATH_FLAG])
      else $error("math flag set without a math trap");

   // software side: unlocked priority writes land, reads show the register
   a_prio_write: assert property ( // [RULE_14]
      wr_prio && !ctrl_q[TSC_NEST_DIS] && !i_prio_load |=> prio_q == $past(pwdata[2:0]))
      else $error("priority write lost while nesting allowed");

   a_read_prio: assert property ( // [RULE_16]
      setup && !pwrite && prio_hit |=> prdata == {29'h0000_0000, $past(prio_q)})
      else $error("priority read mismatch");

   // hardware never moves control bits; only an upper lane write does
   a_ctrl_hold: assert property ( // [RULE_01]
      !(wr_ctrl && pstrb[1]) |=> $stable(ctrl_q[TSC_NEST_DIS]) && $stable(ctrl_q[TSC_OVA_EN])
      && $stable(ctrl_q[TSC_OVB_EN]) && $stable(ctrl_q[TSC_COV_EN]))
      else $error("control bit moved without a write");

   c_ovf_trap:   cover property (i_ovf_a && ctrl_q[TSC_OVA_EN]);
   c_set_wins:   cover property (i_stack_fault && wr_ctrl && !pwdata[TSC_STACK_FLAG]);
   c_clear_flag: cover property (ctrl_q[TSC_MATH_FLAG] ##1 wr_ctrl ##1 !ctrl_q[TSC_MATH_FLAG]);
   c_prio_write: cover property (wr_prio && !ctrl_q[TSC_NEST_DIS]);
   c_bad_addr:   cover property (access && pslverr);
endmodule

// [dv/trap_status_control_register_tb_top.sv]
`timescale 1ns/1ps
module trap_status_control_register_tb_top
   import tsc_pkg::*;
;
   localparam int LIMIT = 5000;  // cycles; the whole run needs well under a thousand
   logic        i_ref_clk;
   logic        i_arst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [9:0]  ev;
   logic        i_prio_load;
   logic [2:0]  i_prio_value;
   logic        o_nesting_disable;
   logic        o_math_trap;
   logic        o_any_trap;
   logic [2:0]  o_cpu_priority_level;
   int          failures;
   int          comparisons;
   int          cycles;
   logic [31:0] rd;
   logic        err;
   // flag position for each event line, in the order of ev
   int unsigned flag_pos [10] = '{TSC_OVA_FLAG, TSC_OVB_FLAG, TSC_COVA_FLAG, TSC_COVB_FLAG,
      TSC_SHIFT_FLAG, TSC_DIV0_FLAG, TSC_DMA_FLAG, TSC_ADDR_FLAG, TSC_STACK_FLAG, TSC_OSC_FLAG};

   tsc_trap_status_control dut (
      .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .i_ovf_a(ev[0]), .i_ovf_b(ev[1]),
      .i_cat_a(ev[2]), .i_cat_b(ev[3]), .i_bad_shift(ev[4]), .i_zero_div(ev[5]),
      .i_dma_fault(ev[6]), .i_addr_fault(ev[7]), .i_stack_fault(ev[8]),
      .i_osc_fault(ev[9]), .i_prio_load(i_prio_load), .i_prio_value(i_prio_value),
      .o_nesting_disable(o_nesting_disable), .o_math_trap(o_math_trap),
      .o_any_trap(o_any_trap), .o_cpu_priority_level(o_cpu_priority_level)
   );

   // free-running clock, 8 ns period
   always
   begin
      #4 i_ref_clk = ~i_ref_clk;
   end

   // hang guard: a stuck handshake ends the run as a failure
   always @(posedge i_ref_clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         $display("Error timeout after %0d cycles", cycles);
         failures++;
         close_out();
      end
   end

   task automatic close_out();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", name, exp, got);
         failures++;
      end
   endtask

   // one apb transfer; request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge i_ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge i_ref_clk);
      penable <= 1'b1;
      do
         @(posedge i_ref_clk);
      while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(negedge i_ref_clk);
   endtask

   // reset values of both registers, pready and the nesting, any trap and priority outputs
   task automatic t_reset_values();
      apb(1'b0, TSC_CTRL_OFS, 32'h0, 4'hf);
      chk("ctrl after reset", {16'h0, TSC_CTRL_RST}, rd);
      apb(1'b0, TSC_PRIO_OFS, 32'h0, 4'hf);
      chk("prio after reset", 32'h0, rd);
      chk("outputs after reset", 32'h0, {27'h0, o_nesting_disable, o_any_trap, o_cpu_priority_level});
      chk("ready idle", 32'h1, {31'h0, pready});
   endtask

   // every implemented bit read/write, bit 0 stays zero, strobes gate lanes
   task automatic t_access();
      apb(1'b1, TSC_CTRL_OFS, 32'h0000ffff, 4'hf);
      apb(1'b0, TSC_CTRL_OFS, 32'h0, 4'hf);
      chk("ctrl all ones", 32'h0000fffe, rd);
      apb(1'b1, TSC_CTRL_OFS, 32'h0000ff01, 4'h1);
      apb(1'b0, TSC_CTRL_OFS, 32'h0, 4'hf);
      chk("ctrl low lane", 32'h0000ff00, rd);
      apb(1'b1, TSC_CTRL_OFS, 32'h0, 4'h2);
      apb(1'b0, TSC_CTRL_OFS, 32'h0, 4'hf);
      chk("ctrl high lane", 32'h0, rd);
      apb(1'b0, 12'h008, 32'h0, 4'hf);
      chk("unmapped error", 32'h1, {31'h0, err});
   endtask

   // each event with the overflow enables on or off, flag and strobe checked
   task automatic t_traps(input logic en);
      logic [15:0] ens;
      logic        fires;
      logic [15:0] exp;
      ens = en ? 16'h0700 : 16'h0000;
      apb(1'b1, TSC_CTRL_OFS, {16'h0, ens}, 4'hf);
      for (int i = 0; i < 10; i++)
      begin
         fires = en || i >= 4;
         @(posedge i_ref_clk);
         ev <= 10'h1 << i;
         @(negedge i_ref_clk);
         chk("any trap strobe", {31'h0, fires}, {31'h0, o_any_trap});
         chk("math trap strobe", {31'h0, fires && i < 6}, {31'h0, o_math_trap});
         @(posedge i_ref_clk);
         ev <= 10'h0;
         exp = ens;
         if (fires)
            exp = exp | (16'h1 << flag_pos[i]) | ((i < 6) ? 16'h0010 : 16'h0);
         repeat (2)
         begin
            apb(1'b0, TSC_CTRL_OFS, 32'h0, 4'hf);
            chk("flags after event", {16'h0, exp}, rd);
         end
         apb(1'b1, TSC_CTRL_OFS, {16'h0, ens}, 4'hf);
         apb(1'b0, TSC_CTRL_OFS, 32'h0, 4'hf);
         chk("flags cleared", {16'h0, ens}, rd);
      end
   endtask

   // nesting lock freezes software priority writes, core load still lands
   task automatic t_nesting();
      apb(1'b1, TSC_CTRL_OFS, 32'h00008000, 4'h2);
      chk("nesting disabled", 32'h1, {31'h0, o_nesting_disable});
      apb(1'b1, TSC_PRIO_OFS, 32'h5, 4'hf);
      apb(1'b0, TSC_PRIO_OFS, 32'h0, 4'hf);
      chk("prio locked", 32'h0, rd);
      @(posedge i_ref_clk);
      i_prio_load  <= 1'b1;
      i_prio_value <= 3'h3;
      @(posedge i_ref_clk);
      i_prio_load  <= 1'b0;
      @(negedge i_ref_clk);
      chk("core prio load", 32'h3, {29'h0, o_cpu_priority_level});
      apb(1'b1, TSC_CTRL_OFS, 32'h0, 4'hf);
      chk("nesting enabled", 32'h0, {31'h0, o_nesting_disable});
      apb(1'b1, TSC_PRIO_OFS, 32'h6, 4'h1);
      apb(1'b0, TSC_PRIO_OFS, 32'h0, 4'hf);
      chk("prio written", 32'h6, rd);
      chk("prio output", 32'h6, {29'h0, o_cpu_priority_level});
   endtask

   // a stack fault in the access cycle of a clearing write keeps its flag
   task automatic t_set_wins();
      @(posedge i_ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= 1'b1;
      paddr   <= TSC_CTRL_OFS;
      pwdata  <= 32'h0;
      pstrb   <= 4'hf;
      @(posedge i_ref_clk);
      penable <= 1'b1;
      ev      <= 10'h100;
      do
         @(posedge i_ref_clk);
      while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      ev      <= 10'h0;
      apb(1'b0, TSC_CTRL_OFS, 32'h0, 4'hf);
      chk("set beats clear", 32'h4, rd);
   endtask

   initial
   begin
      i_ref_clk = 1'b0;
      i_arst_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      ev = 10'h0;
      i_prio_load = 1'b0;
      i_prio_value = 3'h0;
      failures = 0;
      comparisons = 0;
      cycles = 0;
      // reset held ten cycles, then three edges for the internal release
      repeat (10) @(posedge i_ref_clk);
      i_arst_n <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      t_reset_values();
      t_access();
      t_traps(1'b0);
      t_traps(1'b1);
      t_nesting();
      t_set_wins();
      close_out();
   end
endmodule
